// ### verilog/frc_defines.svh
// frc_defines.svh: register indexes, field positions, resets, timing
// assumes: included by frc_core; byte address = index * 4
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH
// register indexes
`define FRC_IX_SCAN 8'h91
`define FRC_IX_HDMI 8'hBA
`define FRC_IX_CTRL 8'hBF
`define FRC_IX_FILL_A 8'hC0
`define FRC_IX_FILL_B 8'hC1
`define FRC_IX_FILL_C 8'hC2
`define FRC_IX_HOLD 8'hC9
`define FRC_IX_LPF_HI 8'hAB
`define FRC_IX_LPF_LO 8'hAC
`define FRC_IX_LL_HI 8'h8F
`define FRC_IX_LL_LO 8'h90
`define FRC_IX_PRIM 8'hE0
`define FRC_IX_STD 8'hE1
`define FRC_IX_VFREQ 8'hE2
`define FRC_IX_STATUS 8'hFF
// field positions
`define FRC_B_SCAN 6
`define FRC_B_STATUS 4
// reset values
`define FRC_RST_SCAN 1'b1
`define FRC_RST_EN 1'b1
`define FRC_RST_AUTO 1'b1
// built-in blue
`define FRC_BLUE_GR 24'h000087
`define FRC_BLUE_COMP 24'h2372D4
`define FRC_PRIM_GR 4'h2
// decoded frame lengths per standard
`define FRC_FL_0 12'h20D
`define FRC_FL_1 12'h271
`define FRC_FL_2 12'h2EE
`define FRC_FL_3 12'h465
`define FRC_VF_50 3'h1
// free-run raster
`define FRC_DEF_LL 12'h35A
`define FRC_HS_W 12'h02C
`define FRC_VS_W 12'h003
`define FRC_HBLANK 12'h08A
`define FRC_VBLANK 12'h02D
// link clock loss timeout
`define FRC_CLK_MHZ 125
`define FRC_LOSS_NS 1000
`define FRC_LOSS_CYC (`FRC_LOSS_NS * `FRC_CLK_MHZ / 1000)
`endif

// ### verilog/frc_pkg.sv
// frc_pkg: carrier and state types of the free-run block
// assumes: nothing beyond standard SystemVerilog
package frc_pkg;
	typedef struct packed {
		logic hs;
		logic vs;
		logic de;
		logic [23:0] data;
	} frc_vid_t;
	typedef struct packed {
		logic scan;
		logic en;
		logic pol;
		logic force_run;
		logic autoc;
		logic man;
		logic [7:0] fa;
		logic [7:0] fb;
		logic [7:0] fc;
		logic hold_dis;
		logic [11:0] ideal;
		logic [10:0] ll;
		logic [3:0] prim;
		logic [5:0] std;
		logic [2:0] vfreq;
	} frc_regs_t;
	typedef struct packed {
		frc_regs_t r;
		logic sync1;
		logic sync2;
		logic sync3;
		logic [7:0] loss_cnt;
		logic clk_lost;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic hs_d;
		logic vs_d;
		logic [11:0] lcnt;
		logic [11:0] meas;
		logic meas_ok;
		logic [11:0] held;
		logic [11:0] hcnt;
		logic [11:0] vcnt;
		frc_vid_t vout;
		logic freerun;
	} frc_state_t;
endpackage

// ### verilog/frc_core.sv
// frc_core: free-run decision, free-run raster and fill color insertion
// assumes: APB3 master on pclk; vid_in is decoded video on pclk;
// tmds_clk is an asynchronous pin sampled here
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "frc_defines.svh"

// Summary of operation
// - scan bit 0 progressive, 1 interlaced
// - zero ideal lines: decode from format, standard
// - nonzero ideal lines with scan give field
// - ideal lines never touch decoded video path
// - policy 0: free-run on lost TMDS clock
// - policy 1: also on resolution mismatch
// - HDMI enable gates both policies
// - hold on: keep last measured lines
// - hold off: standard from format selections
// - policy 1 expects programmed custom resolution
// - forced free-run always outputs fill color
// - automatic: fill only on lost input or, under policy 1, on mismatch
// - force bit makes core free-run
// - auto enable inserts fill while free-running
// - manual select picks programmed fill values
// - built-in blue values per format
// - three 8-bit fill values reset zero
// - status bit 4 shows free running
// - free-run gives stable timing; data is fill only with auto or force set
module frc_core #(
	parameter int LOSS_CYC = `FRC_LOSS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tmds_clk,
	input wire frc_pkg::frc_vid_t vid_in,
	output frc_pkg::frc_vid_t vid_out,
	output logic freerun_status
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	generate
		if (LOSS_CYC < 2 || LOSS_CYC > 255) begin : g_bad
			$error("LOSS_CYC must lie in 2..255");
		end
	endgenerate

	localparam logic [7:0] LOSS_LAST = 8'(LOSS_CYC - 1);

	frc_pkg::frc_state_t st_reg;
	frc_pkg::frc_state_t st_next;
	logic tedge;
	logic [11:0] dec_frame;
	logic [11:0] dec_field;
	logic [11:0] ideal_field;
	logic [11:0] exp_field;
	logic [11:0] fr_field;
	logic [11:0] line_len;
	logic mismatch;
	logic freerun;
	logic fill;
	logic [23:0] color;

	// ------------------------------------------------------------
	// free-run decision
	// ------------------------------------------------------------
	// frame length decoded from the format selections
	always_comb begin
		case (st_reg.r.std[1:0])
			2'h0: dec_frame = `FRC_FL_0;
			2'h1: dec_frame = `FRC_FL_1;
			2'h2: dec_frame = `FRC_FL_2;
			default: dec_frame = `FRC_FL_3;
		endcase
		if (st_reg.r.std[1:0] == 2'h0 && st_reg.r.vfreq == `FRC_VF_50) begin
			dec_frame = `FRC_FL_1;
		end
	end

	// interlaced halves frame into field
	assign dec_field = st_reg.r.scan ? dec_frame >> 1 : dec_frame;
	assign ideal_field = st_reg.r.scan ? st_reg.r.ideal >> 1
		: st_reg.r.ideal;
	// expected field for the mismatch test
	assign exp_field = (st_reg.r.ideal != 12'h000) ? ideal_field
		: dec_field;
	// field length the raster free-runs into
	assign fr_field = (st_reg.r.ideal != 12'h000) ? ideal_field
		: (!st_reg.r.hold_dis && st_reg.held != 12'h000) ? st_reg.held
		: dec_field;
	assign line_len = (st_reg.r.ll != 11'h000) ? {1'b0, st_reg.r.ll}
		: `FRC_DEF_LL;
	assign mismatch = st_reg.meas_ok && st_reg.meas != exp_field;
	assign freerun = st_reg.r.force_run
		|| (st_reg.r.en
		&& (st_reg.clk_lost || (st_reg.r.pol && mismatch)));
	// fill only while free-running, unless forced
	assign fill = st_reg.r.force_run
		|| (st_reg.r.autoc && freerun);
	assign color = st_reg.r.man
		? {st_reg.r.fa, st_reg.r.fb, st_reg.r.fc}
		: (st_reg.r.prim == `FRC_PRIM_GR) ? `FRC_BLUE_GR
		: `FRC_BLUE_COMP;
	// any transition of the synchronised link clock
	assign tedge = st_reg.sync2 ^ st_reg.sync3;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] idx;
		logic hit;
		logic [7:0] rd;
		idx = paddr[9:2];
		hit = 1'b1;
		rd = 8'h00;
		st_next = st_reg;

		// link clock synchroniser and loss watchdog
		st_next.sync1 = tmds_clk;
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		if (tedge) begin
			st_next.loss_cnt = 8'h00;
			st_next.clk_lost = 1'b0;
		end else if (st_reg.loss_cnt == LOSS_LAST) begin
			st_next.clk_lost = 1'b1;
		end else begin
			st_next.loss_cnt = st_reg.loss_cnt + 8'h01;
		end

		// register read mux and decode
		case (idx)
			`FRC_IX_SCAN: rd[`FRC_B_SCAN] = st_reg.r.scan;
			`FRC_IX_HDMI: rd = {6'h00, st_reg.r.pol, st_reg.r.en};
			`FRC_IX_CTRL: rd = {5'h00, st_reg.r.man, st_reg.r.autoc,
				st_reg.r.force_run};
			`FRC_IX_FILL_A: rd = st_reg.r.fa;
			`FRC_IX_FILL_B: rd = st_reg.r.fb;
			`FRC_IX_FILL_C: rd = st_reg.r.fc;
			`FRC_IX_HOLD: rd = {7'h00, st_reg.r.hold_dis};
			`FRC_IX_LPF_HI: rd = st_reg.r.ideal[11:4];
			`FRC_IX_LPF_LO: rd = {st_reg.r.ideal[3:0], 4'h0};
			`FRC_IX_LL_HI: rd = {5'h00, st_reg.r.ll[10:8]};
			`FRC_IX_LL_LO: rd = st_reg.r.ll[7:0];
			`FRC_IX_PRIM: rd = {4'h0, st_reg.r.prim};
			`FRC_IX_STD: rd = {2'h0, st_reg.r.std};
			`FRC_IX_VFREQ: rd = {5'h00, st_reg.r.vfreq};
			`FRC_IX_STATUS: rd[`FRC_B_STATUS] = st_reg.freerun;
			default: hit = 1'b0;
		endcase

		// apb: answer in the first access cycle
		st_next.pready = psel && !penable;
		if (psel && !penable) begin
			st_next.pslverr = !hit;
			st_next.prdata = (pwrite || !hit) ? 32'h0000_0000
				: {24'h00_0000, rd};
		end
		if (psel && penable && st_reg.pready && pwrite) begin
			case (idx)
				`FRC_IX_SCAN: st_next.r.scan = pwdata[`FRC_B_SCAN];
				`FRC_IX_HDMI: begin
					st_next.r.en = pwdata[0];
					st_next.r.pol = pwdata[1];
				end
				`FRC_IX_CTRL: begin
					st_next.r.force_run = pwdata[0];
					st_next.r.autoc = pwdata[1];
					st_next.r.man = pwdata[2];
				end
				`FRC_IX_FILL_A: st_next.r.fa = pwdata[7:0];
				`FRC_IX_FILL_B: st_next.r.fb = pwdata[7:0];
				`FRC_IX_FILL_C: st_next.r.fc = pwdata[7:0];
				`FRC_IX_HOLD: st_next.r.hold_dis = pwdata[0];
				`FRC_IX_LPF_HI: st_next.r.ideal[11:4] = pwdata[7:0];
				`FRC_IX_LPF_LO: st_next.r.ideal[3:0] = pwdata[7:4];
				`FRC_IX_LL_HI: st_next.r.ll[10:8] = pwdata[2:0];
				`FRC_IX_LL_LO: st_next.r.ll[7:0] = pwdata[7:0];
				`FRC_IX_PRIM: st_next.r.prim = pwdata[3:0];
				`FRC_IX_STD: st_next.r.std = pwdata[5:0];
				`FRC_IX_VFREQ: st_next.r.vfreq = pwdata[2:0];
				default: st_next.r = st_reg.r;
			endcase
		end

		// measure lines per field of the incoming stream
		st_next.hs_d = vid_in.hs;
		st_next.vs_d = vid_in.vs;
		if (vid_in.vs && !st_reg.vs_d) begin
			st_next.meas = st_reg.lcnt;
			st_next.meas_ok = !st_reg.clk_lost;
			// a line that starts together with the field still counts
			st_next.lcnt = (vid_in.hs && !st_reg.hs_d) ? 12'h001
				: 12'h000;
		end else if (vid_in.hs && !st_reg.hs_d) begin
			st_next.lcnt = st_reg.lcnt + 12'h001;
		end
		if (st_reg.clk_lost) begin
			st_next.meas_ok = 1'b0;
		end
		// buffer last good measurement unless hold is disabled
		if (!st_reg.r.hold_dis && st_reg.meas_ok) begin
			st_next.held = st_reg.meas;
		end

		// free-running raster, always counting for a clean entry
		if (st_reg.hcnt >= line_len - 12'h001) begin
			st_next.hcnt = 12'h000;
			if (st_reg.vcnt >= fr_field - 12'h001) begin
				st_next.vcnt = 12'h000;
			end else begin
				st_next.vcnt = st_reg.vcnt + 12'h001;
			end
		end else begin
			st_next.hcnt = st_reg.hcnt + 12'h001;
		end

		// output select: raster or decoded timing, fill or data
		if (freerun) begin
			st_next.vout.hs = st_reg.hcnt < `FRC_HS_W;
			st_next.vout.vs = st_reg.vcnt < `FRC_VS_W;
			st_next.vout.de = st_reg.hcnt >= `FRC_HBLANK
				&& st_reg.vcnt >= `FRC_VBLANK;
		end else begin
			st_next.vout.hs = vid_in.hs;
			st_next.vout.vs = vid_in.vs;
			st_next.vout.de = vid_in.de;
		end
		st_next.vout.data = fill ? color : vid_in.data;
		st_next.freerun = freerun;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.r.scan <= `FRC_RST_SCAN;
			st_reg.r.en <= `FRC_RST_EN;
			st_reg.r.autoc <= `FRC_RST_AUTO;
			st_reg.clk_lost <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// output ports straight from the state register
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign vid_out = st_reg.vout;
	assign freerun_status = st_reg.freerun;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_force_run: assert property (st_reg.r.force_run |=> freerun_status)
		else $error("force did not free-run");
	a_loss_run: assert property (
		st_reg.r.en && st_reg.clk_lost |=> freerun_status)
		else $error("lost clock did not free-run");
	a_disable_norun: assert property (
		!st_reg.r.en && !st_reg.r.force_run |=> !freerun_status)
		else $error("free-run while disabled");
	a_mismatch_run: assert property (
		st_reg.r.en && st_reg.r.pol && mismatch |=> freerun_status)
		else $error("mismatch did not free-run");
	a_policy0_resume: assert property (
		!st_reg.r.force_run && !st_reg.r.pol && !st_reg.clk_lost
		|=> !freerun_status ##0 vid_out.de == $past(vid_in.de))
		else $error("did not resume video");
	a_force_fill: assert property (
		st_reg.r.force_run |=> vid_out.data == $past(color))
		else $error("forced fill missing");
	a_auto_off: assert property (
		!st_reg.r.force_run && !st_reg.r.autoc
		|=> vid_out.data == $past(vid_in.data))
		else $error("fill inserted with auto off");
	a_manual_color: assert property (
		fill && st_reg.r.man
		|=> vid_out.data == {$past(st_reg.r.fa), $past(st_reg.r.fb),
		$past(st_reg.r.fc)})
		else $error("manual fill wrong");
	a_blue_comp: assert property (
		fill && !st_reg.r.man && st_reg.r.prim != `FRC_PRIM_GR
		|=> vid_out.data == 24'h2372D4)
		else $error("component blue wrong");
	a_loss_timeout: assert property (
		!tedge && st_reg.loss_cnt == LOSS_LAST |=> st_reg.clk_lost)
		else $error("loss timeout late");
	a_ideal_field: assert property (
		st_reg.r.ideal != 12'h000 && !st_reg.r.scan
		|-> fr_field == st_reg.r.ideal)
		else $error("ideal field not used");
	a_apb_ready: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("apb ready timing");

	// ------------------------------------------------------------
	// output path checks
	// ------------------------------------------------------------
	// graphics formats fill with the graphics blue
	a_graph_blue: assert property (
		fill && !st_reg.r.man && st_reg.r.prim == `FRC_PRIM_GR
		|=> vid_out.data == `FRC_BLUE_GR)
		else $error("graphics blue wrong");
	a_freerun_fill: assert property (
		st_reg.r.autoc && freerun
		|=> freerun_status && vid_out.data == $past(color))
		else $error("auto fill missing");
	a_pass_timing: assert property (
		!freerun |=> vid_out.hs == $past(vid_in.hs)
		&& vid_out.vs == $past(vid_in.vs) && vid_out.de == $past(vid_in.de))
		else $error("decoded timing not passed");
	a_status_read: assert property (
		psel && !penable && !pwrite && paddr[9:2] == `FRC_IX_STATUS
		|=> prdata[`FRC_B_STATUS] == $past(freerun_status))
		else $error("status read wrong");
	// link watchdog clears on any returning link clock edge
	a_clk_back: assert property (tedge |=> !st_reg.clk_lost)
		else $error("lost flag did not clear");

	c_force: cover property (st_reg.r.force_run ##1 freerun_status);
	c_loss: cover property ($rose(st_reg.clk_lost) ##1 freerun_status);
	c_mismatch: cover property (st_reg.r.pol && mismatch && st_reg.r.en);
	c_resume: cover property ($fell(freerun_status));
	c_manual: cover property (fill && st_reg.r.man);

endmodule

// ### dv/frc_source_model.sv
// frc_source_model: behavioural link source in front of the free-run block
// assumes: pclk domain video; link clock unrelated in phase to pclk
`timescale 1ns/1ps
module frc_source_model (
	input wire logic pclk,
	input wire logic link_on,
	input wire logic [23:0] rnd,
	output logic tmds_clk,
	output frc_pkg::frc_vid_t vid
);
	logic [4:0] h;
	logic [3:0] v;
	// link clock, standing still while the cable is out
	initial begin
		tmds_clk = 1'b0;
		#3;
		forever begin
			#62.5;
			if (link_on) tmds_clk = ~tmds_clk;
		end
	end
	// raster of 20 cycles by 10 lines carrying random pixels
	initial begin
		h = 5'h00;
		v = 4'h0;
		vid = '0;
	end
	always @(posedge pclk) begin
		h <= (h == 5'h13) ? 5'h00 : h + 5'h01;
		if (h == 5'h13) v <= (v == 4'h9) ? 4'h0 : v + 4'h1;
		vid.hs <= (h < 5'h02);
		vid.vs <= (v == 4'h0);
		vid.de <= (h > 5'h03) && (v > 4'h1);
		vid.data <= rnd;
	end
endmodule

// ### dv/tb_video_free_run_and_fill_color.sv
// tb_video_free_run_and_fill_color: self-checking bench of frc_core
// assumes: frc_core on APB, frc_source_model on the link side
`timescale 1ns/1ps
module tb_video_free_run_and_fill_color;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic freerun_status, tmds_clk, link_on, look;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, lfsr;
	frc_pkg::frc_vid_t pd;
	logic [9:0] re;
	logic [25:0] ve;
	frc_pkg::frc_vid_t vid_in, vid_out;
	int num_errors, check_count, cyc;
	logic [9:0] rq[$];
	logic [25:0] vq[$];
	logic [7:0] ri[7] = '{8'h91, 8'hBA, 8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC9};
	logic [7:0] rv[7] = '{8'h40, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [23:0] BLUE = 24'h2372D4;
	localparam logic [11:0] LINE_LEN = 12'h35A;
	localparam logic [11:0] HS_WIDTH = 12'h02C;
	frc_core #(.LOSS_CYC(20)) u_frc_core (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tmds_clk(tmds_clk), .vid_in(vid_in),
		.vid_out(vid_out), .freerun_status(freerun_status));
	frc_source_model u_frc_source_model (.pclk(pclk), .link_on(link_on),
		.rnd(lfsr[23:0]), .tmds_clk(tmds_clk), .vid(vid_in));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_vid(input logic [24:0] got, input logic [24:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t video %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_tim(input frc_pkg::frc_vid_t got,
		input frc_pkg::frc_vid_t exp);
		check_count++;
		if ({got.hs, got.vs, got.de} !== {exp.hs, exp.vs, exp.de}) begin
			num_errors++;
			$display("mismatch %0t timing %h expected %h", $time,
				{got.hs, got.vs, got.de}, {exp.hs, exp.vs, exp.de});
		end
	endtask
	task automatic cmp_line(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t line %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one apb transfer; for a read d is the expected byte
	task automatic apb(input logic w, input logic [7:0] ix,
		input logic [7:0] d, input logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, ix, 2'h0};
		pwdata <= {24'h000000, d};
		rq.push_back({w, err, d});
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		apb(1'b1, ix, d, 1'b0);
	endtask
	task automatic rd(input logic [7:0] ix, input logic [7:0] e);
		apb(1'b0, ix, e, 1'b0);
	endtask
	// note expected status and pixel; p means pixel passes through
	task automatic vchk(input logic p, input logic st, input logic [23:0] e);
		repeat (2) @(posedge pclk);
		vq.push_back({p, st, e});
		look <= 1'b1;
		@(posedge pclk);
		look <= 1'b0;
	endtask
	// hs width and line period of the free-run raster in pclk cycles
	task automatic line_chk();
		int hi, n;
		hi = 0;
		n = 0;
		do @(posedge pclk); while (vid_out.hs !== 1'b0);
		do @(posedge pclk); while (vid_out.hs !== 1'b1);
		do begin
			@(posedge pclk);
			hi++;
		end while (vid_out.hs === 1'b1);
		n = hi;
		do begin
			@(posedge pclk);
			n++;
		end while (vid_out.hs !== 1'b1);
		cmp_line(hi[11:0], HS_WIDTH);
		cmp_line(n[11:0], LINE_LEN);
	endtask
	// ----------------------------------------------------------------
	// clock, random pixels, monitor and timeout
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		pd <= vid_in;
		lfsr <= lfsr_step(lfsr);
		cyc <= cyc + 1;
		if (psel && penable && pready === 1'b1 && rq.size() > 0) begin
			re = rq.pop_front();
			if (re[9]) cmp_rd({pslverr, 32'h0}, {re[8], 32'h0});
			else cmp_rd({pslverr, prdata}, {re[8], 24'h0, re[7:0]});
		end
		if (look) begin
			ve = vq.pop_front();
			cmp_vid({freerun_status, vid_out.data},
				{ve[24], ve[25] ? pd.data : ve[23:0]});
			if (!ve[24]) cmp_tim(vid_out, pd);
		end
		if (cyc > 20000) begin
			num_errors++;
			complete_run();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, look} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		link_on = 1'b1;
		lfsr = 32'hDFD5;
		{num_errors, check_count, cyc} = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ri[i]) rd(ri[i], rv[i]);
		apb(1'b0, 8'h10, 8'h00, 1'b1);
		$display("test reset values done");
		repeat (100) @(posedge pclk);
		vchk(1'b1, 1'b0, 24'h0);
		rd(8'hFF, 8'h00);
		wr(8'hBF, 8'h03);
		vchk(1'b0, 1'b1, BLUE);
		line_chk();
		rd(8'hFF, 8'h10);
		wr(8'hE0, 8'h02);
		vchk(1'b0, 1'b1, 24'h000087);
		wr(8'hC0, 8'h11);
		wr(8'hC1, 8'h22);
		wr(8'hC2, 8'h33);
		wr(8'hBF, 8'h07);
		vchk(1'b0, 1'b1, 24'h112233);
		wr(8'hBF, 8'h05);
		vchk(1'b0, 1'b1, 24'h112233);
		wr(8'hBF, 8'h02);
		wr(8'hE0, 8'h00);
		vchk(1'b1, 1'b0, 24'h0);
		$display("test forced fill done");
		link_on <= 1'b0;
		repeat (40) @(posedge pclk);
		vchk(1'b0, 1'b1, BLUE);
		wr(8'hBF, 8'h00);
		vchk(1'b1, 1'b1, 24'h0);
		wr(8'hBF, 8'h02);
		wr(8'hBA, 8'h00);
		vchk(1'b1, 1'b0, 24'h0);
		wr(8'hBA, 8'h01);
		link_on <= 1'b1;
		repeat (40) @(posedge pclk);
		vchk(1'b1, 1'b0, 24'h0);
		$display("test link loss done");
		// hold disable stays 0: the link may carry deep colour
		wr(8'h91, 8'h00);
		wr(8'hAC, 8'hA0);
		wr(8'hBA, 8'h03);
		repeat (500) @(posedge pclk);
		vchk(1'b1, 1'b0, 24'h0);
		wr(8'hAC, 8'hB0);
		repeat (500) @(posedge pclk);
		vchk(1'b0, 1'b1, BLUE);
		wr(8'hBA, 8'h01);
		vchk(1'b1, 1'b0, 24'h0);
		wr(8'h91, 8'h40);
		wr(8'hAB, 8'h01);
		wr(8'hAC, 8'h40);
		wr(8'hBA, 8'h03);
		repeat (500) @(posedge pclk);
		vchk(1'b1, 1'b0, 24'h0);
		wr(8'hAB, 8'h00);
		wr(8'hAC, 8'h00);
		repeat (500) @(posedge pclk);
		vchk(1'b0, 1'b1, BLUE);
		$display("test format mismatch done");
		complete_run();
	end
endmodule
